// ===== rtl/thermo_device.sv
// sensor end: id code, scratchpad, conversion, alarm and crc
`timescale 1ns/100ps
module thermo_device import thermo_pkg::*; #(
	parameter int          CONV_CYCLES = CONV_CYC,
	parameter logic [7:0]  FAMILY      = 8'h5a,         // arbitrary
	parameter logic [47:0] SERIAL      = 48'h0012_3456_789a // arbitrary
) (
	// clock and reset
	input  wire logic        SYS_CLK,
	input  wire logic        RST,
	// link
	thermo_link_if.device    link,
	// sensor side
	input  wire logic [15:0] TEMP_SAMPLE,
	output logic      [15:0] TEMP_RESULT,
	output logic             CONV_BUSY,
	output logic             ALARM
);
	typedef enum logic [3:0] {
		S_WAIT    = 4'h0,
		S_ROMCMD  = 4'h1,
		S_READID  = 4'h2,
		S_MATCH   = 4'h3,
		S_SEARCH  = 4'h4,
		S_FUNC    = 4'h5,
		S_READSP  = 4'h6,
		S_WRITESP = 4'h7,
		S_CONV    = 4'h8
	} state_t;

	localparam logic [63:0] ID_CODE = {id_crc({SERIAL, FAMILY}), SERIAL, FAMILY};

	state_t      state_r;
	logic [6:0]  idx_r;
	logic [1:0]  sub_r;
	logic [7:0]  cmd_r;
	logic [23:0] wr_r;
	logic [15:0] temp_r;
	logic [7:0]  upper_r;
	logic [7:0]  lower_r;
	logic [1:0]  res_r;
	logic        alarm_r;
	logic        busy_r;
	logic [31:0] cnt_r;
	logic [7:0]  crc_r;
	logic        d_oe_r;
	logic        rx;
	logic        id_bit;
	logic [7:0]  byte_in;
	logic [7:0]  cfg_byte;
	logic [63:0] scratch;
	logic        tx_en;
	logic        tx_bit;
	logic        conv_go;
	logic [15:0] masked;
	logic [7:0]  t8;

	assign rx       = link.line;
	assign id_bit   = ID_CODE[idx_r[5:0]];
	assign byte_in  = {rx, cmd_r[7:1]};
	assign cfg_byte = {1'b0, res_r, CFG_ONES};
	assign scratch  = {SP_RSV7, SP_RSV6, SP_RSV5, cfg_byte, lower_r, upper_r, temp_r};
	assign masked   = TEMP_SAMPLE & res_mask(res_r);
	assign t8       = masked[11:4];
	assign conv_go  = link.slot && state_r == S_FUNC && idx_r == 7'h07
		&& byte_in == CMD_CONVERT;

	// bit offered in the next read slot
	always_comb begin
		tx_en  = 1'b0;
		tx_bit = 1'b1;
		case (state_r)
			S_READID: begin
				tx_en  = 1'b1;
				tx_bit = id_bit;
			end
			S_SEARCH: begin
				tx_en  = (sub_r != 2'h2);
				tx_bit = id_bit ^ (sub_r == 2'h1);
			end
			S_READSP: begin
				tx_en  = 1'b1;
				tx_bit = idx_r[6] ? crc_r[idx_r[2:0]] : scratch[idx_r[5:0]];
			end
			S_CONV: begin
				tx_en  = 1'b1;
				tx_bit = ~busy_r;
			end
			default: begin
				tx_en  = 1'b0;
			end
		endcase
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			d_oe_r <= 1'b0;
		end else begin
			d_oe_r <= tx_en & ~tx_bit;
		end
	end

	// command sequencer
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			state_r <= S_WAIT;
			idx_r   <= 7'h00;
			sub_r   <= 2'h0;
		end else if (link.link_rst) begin
			state_r <= S_ROMCMD;
			idx_r   <= 7'h00;
			sub_r   <= 2'h0;
		end else if (link.slot) begin
			idx_r <= idx_r + 7'h01;
			case (state_r)
				S_ROMCMD: begin
					if (idx_r == 7'h07) begin
						idx_r <= 7'h00;
						case (byte_in)
							CMD_READ_ID:   state_r <= S_READID;
							CMD_MATCH_ID:  state_r <= S_MATCH;
							CMD_SKIP_ID:   state_r <= S_FUNC;
							CMD_SEARCH:    state_r <= S_SEARCH;
							CMD_ALARM_SRC: state_r <= alarm_r ? S_SEARCH : S_WAIT;
							default:       state_r <= S_WAIT;
						endcase
					end
				end
				S_READID: begin
					if (idx_r == 7'h3f) begin
						idx_r   <= 7'h00;
						state_r <= S_FUNC;
					end
				end
				S_MATCH: begin
					if (rx != id_bit) begin
						state_r <= S_WAIT;
					end else if (idx_r == 7'h3f) begin
						idx_r   <= 7'h00;
						state_r <= S_FUNC;
					end
				end
				S_SEARCH: begin
					if (sub_r != 2'h2) begin
						idx_r <= idx_r;
						sub_r <= sub_r + 2'h1;
					end else begin
						sub_r <= 2'h0;
						if (rx != id_bit) begin
							state_r <= S_WAIT;
						end else if (idx_r == 7'h3f) begin
							idx_r   <= 7'h00;
							state_r <= S_FUNC;
						end
					end
				end
				S_FUNC: begin
					if (idx_r == 7'h07) begin
						idx_r <= 7'h00;
						case (byte_in)
							CMD_CONVERT:  state_r <= S_CONV;
							CMD_READ_SP:  state_r <= S_READSP;
							CMD_WRITE_SP: state_r <= S_WRITESP;
							default:      state_r <= S_WAIT;
						endcase
					end
				end
				S_READSP: begin
					if (idx_r == 7'h47) begin
						state_r <= S_WAIT;
					end
				end
				S_WRITESP: begin
					if (idx_r == 7'h17) begin
						state_r <= S_WAIT;
					end
				end
				S_CONV: begin
					idx_r <= 7'h00;
				end
				default: begin
					idx_r <= 7'h00;
				end
			endcase
		end
	end

	// command and write byte shifters, LSB first
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			cmd_r <= 8'h00;
			wr_r  <= 24'h000000;
		end else if (link.slot) begin
			cmd_r <= byte_in;
			wr_r  <= {rx, wr_r[23:1]};
		end
	end

	// limits and resolution from write scratchpad
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			upper_r <= UPPER_RST;
			lower_r <= LOWER_RST;
			res_r   <= RES_RST;
		end else if (link.slot && state_r == S_WRITESP && idx_r == 7'h17) begin
			upper_r <= wr_r[8:1];
			lower_r <= wr_r[16:9];
			res_r   <= wr_r[23:22];
		end
	end

	// conversion timer, result and alarm
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			busy_r  <= 1'b0;
			cnt_r   <= 32'h00000000;
			temp_r  <= TEMP_RST;
			alarm_r <= 1'b0;
		end else if (conv_go && !busy_r) begin
			busy_r <= 1'b1;
			cnt_r  <= 32'(CONV_CYCLES) >> (2'h3 - res_r);
		end else if (busy_r) begin
			cnt_r <= cnt_r - 32'h00000001;
			if (cnt_r <= 32'h00000001) begin
				busy_r  <= 1'b0;
				temp_r  <= masked;
				alarm_r <= $signed(t8) > $signed(upper_r)
					|| $signed(t8) < $signed(lower_r);
			end
		end
	end

	// scratchpad crc over bytes 0..7
	always_ff @(posedge SYS_CLK) begin
		if (RST || state_r != S_READSP) begin
			crc_r <= 8'h00;
		end else if (link.slot && !idx_r[6]) begin
			crc_r <= crc_step(crc_r, tx_bit);
		end
	end

	assign link.d_oe   = d_oe_r;
	assign link.d_o    = 1'b0;
	assign TEMP_RESULT = temp_r;
	assign CONV_BUSY   = busy_r;
	assign ALARM       = alarm_r;
endmodule // thermo_device

// ===== rtl/thermo_pkg.sv
// constants, codes and helper functions shared by both link ends
// How it works
// - resolution 9 to 12 bits, 12 default
// - step weight halves per added bit
// - convert command stores signed 16-bit result
// - read scratchpad sends result LSB first
// - 12-bit layout: sign copies, 2^6..2^-4
// - insignificant low bits forced to zero
// - result resets to plus 85 degrees
// - limits compared with sign-aligned result bits
// - alarm set outside limits, every conversion
// - alarm search answered only while alarming
// - id code: family, serial, crc
// - id command needed before function commands
// - crc polynomial x8+x5+x4+1 both ends
// - ninth scratchpad byte is crc
// - master checks crc, device ignores mismatches
// - crc starts zero, fed LSB first
// - shifting crc through leaves zero
// - result low byte 0, high byte 1
// - resolution bits 00..11, default 11, 750ms
package thermo_pkg;
	localparam int          CLK_MHZ   = 200;
	localparam int          CONV_MS   = 750;
	localparam int          CONV_CYC  = CONV_MS * CLK_MHZ * 1000;
	localparam int          SLOT_DIV  = 4;
	localparam logic [15:0] TEMP_RST  = 16'h0550;
	localparam logic [1:0]  RES_RST   = 2'h3;
	localparam logic [7:0]  UPPER_RST = 8'h7f;
	localparam logic [7:0]  LOWER_RST = 8'h80;
	localparam logic [7:0]  CRC_POLY  = 8'h8c;
	localparam logic [7:0]  SP_RSV5   = 8'hff;
	localparam logic [7:0]  SP_RSV6   = 8'h0c;
	localparam logic [7:0]  SP_RSV7   = 8'h10;
	localparam logic [4:0]  CFG_ONES  = 5'h1f;
	// link commands
	localparam logic [7:0]  CMD_READ_ID   = 8'h33;
	localparam logic [7:0]  CMD_MATCH_ID  = 8'h55;
	localparam logic [7:0]  CMD_SKIP_ID   = 8'hcc;
	localparam logic [7:0]  CMD_SEARCH    = 8'hf0;
	localparam logic [7:0]  CMD_ALARM_SRC = 8'hec;
	localparam logic [7:0]  CMD_CONVERT   = 8'h44;
	localparam logic [7:0]  CMD_READ_SP   = 8'hbe;
	localparam logic [7:0]  CMD_WRITE_SP  = 8'h4e;
	// master register map
	localparam logic [7:0]  REG_CTRL     = 8'h00;
	localparam logic [7:0]  REG_STATUS   = 8'h04;
	localparam int          CTRL_NB_LSB  = 8;
	localparam int          CTRL_CRC_EN  = 11;
	localparam int          CTRL_CRC_CLR = 12;
	localparam int          CTRL_LRST    = 13;
	localparam logic [1:0]  AXI_OKAY     = 2'h0;
	localparam logic [1:0]  AXI_SLVERR   = 2'h2;

	function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b);
		logic fb;
		fb = c[0] ^ b;
		crc_step = {1'b0, c[7:1]} ^ (fb ? CRC_POLY : 8'h00);
	endfunction

	function automatic logic [7:0] id_crc(input logic [55:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 0; i < 56; i++) begin
			c = crc_step(c, d[i]);
		end
		return c;
	endfunction

	function automatic logic [15:0] res_mask(input logic [1:0] r);
		res_mask = 16'hffff << (2'h3 - r);
	endfunction
endpackage

// ===== rtl/thermo_link_if.sv
// shared single-line link between master and sensor
`timescale 1ns/100ps
interface thermo_link_if;
	logic slot;
	logic link_rst;
	logic m_o;
	logic m_oe;
	logic d_o;
	logic d_oe;
	logic line;

	// wired-and of both open-drain drivers
	assign line = ~((m_oe & ~m_o) | (d_oe & ~d_o));

	modport device(input slot, input link_rst, input line, output d_o, output d_oe);
	modport master(output slot, output link_rst, output m_o, output m_oe, input line);
endinterface

// ===== rtl/thermo_master.sv
// master end: AXI4-Lite registers driving bit slots on the link
`timescale 1ns/100ps
module thermo_master import thermo_pkg::*; (
	// clock and reset
	input  wire logic        SYS_CLK,
	input  wire logic        RST,
	// AXI4-Lite write
	input  wire logic [31:0] S_AXI_AWADDR,
	input  wire logic        S_AXI_AWVALID,
	output logic             S_AXI_AWREADY,
	input  wire logic [31:0] S_AXI_WDATA,
	input  wire logic [3:0]  S_AXI_WSTRB,
	input  wire logic        S_AXI_WVALID,
	output logic             S_AXI_WREADY,
	output logic      [1:0]  S_AXI_BRESP,
	output logic             S_AXI_BVALID,
	input  wire logic        S_AXI_BREADY,
	// AXI4-Lite read
	input  wire logic [31:0] S_AXI_ARADDR,
	input  wire logic        S_AXI_ARVALID,
	output logic             S_AXI_ARREADY,
	output logic      [31:0] S_AXI_RDATA,
	output logic      [1:0]  S_AXI_RRESP,
	output logic             S_AXI_RVALID,
	input  wire logic        S_AXI_RREADY,
	// link
	thermo_link_if.master    link
);
	logic        awr_r, wr_r, bv_r, arr_r, rv_r;
	logic [1:0]  bresp_r, rresp_r;
	logic [31:0] rdata_r;
	logic [7:0]  aw_r;
	logic [31:0] wd_r;
	logic [3:0]  ws_r;
	logic        awg_r, wg_r;
	logic [13:0] ctrl_r;
	logic        busy_r, phase_r, slot_r, lrst_r, oe_r, crc_en_r;
	logic [3:0]  nb_r;
	logic [7:0]  sh_r, rx_r, crc_r;
	logic [1:0]  div_r;
	logic        do_wr, hit_ctrl, go;
	logic [31:0] status;

	assign do_wr    = awg_r && wg_r && !bv_r;
	assign hit_ctrl = aw_r == REG_CTRL;
	assign go       = do_wr && hit_ctrl && ws_r[1] && !busy_r;
	assign status   = {14'h0000, crc_r == 8'h00, busy_r, crc_r, rx_r};

	// write channels, taken in either order
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			awr_r   <= 1'b1;
			wr_r    <= 1'b1;
			awg_r   <= 1'b0;
			wg_r    <= 1'b0;
			bv_r    <= 1'b0;
			bresp_r <= AXI_OKAY;
			aw_r    <= 8'h00;
			wd_r    <= 32'h00000000;
			ws_r    <= 4'h0;
		end else begin
			if (S_AXI_AWVALID && awr_r) begin
				aw_r  <= S_AXI_AWADDR[7:0];
				awg_r <= 1'b1;
				awr_r <= 1'b0;
			end
			if (S_AXI_WVALID && wr_r) begin
				wd_r <= S_AXI_WDATA;
				ws_r <= S_AXI_WSTRB;
				wg_r <= 1'b1;
				wr_r <= 1'b0;
			end
			if (do_wr) begin
				awg_r   <= 1'b0;
				wg_r    <= 1'b0;
				bv_r    <= 1'b1;
				bresp_r <= (hit_ctrl || aw_r == REG_STATUS) ? AXI_OKAY : AXI_SLVERR;
			end
			if (bv_r && S_AXI_BREADY) begin
				bv_r  <= 1'b0;
				awr_r <= 1'b1;
				wr_r  <= 1'b1;
			end
		end
	end

	// control register, lanes 0 and 1
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			ctrl_r <= 14'h0000;
		end else if (do_wr && hit_ctrl && !busy_r) begin
			if (ws_r[0]) begin
				ctrl_r[7:0] <= wd_r[7:0];
			end
			if (ws_r[1]) begin
				ctrl_r[13:8] <= wd_r[13:8];
			end
		end
	end

	// read channel
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			arr_r   <= 1'b1;
			rv_r    <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= AXI_OKAY;
		end else if (S_AXI_ARVALID && arr_r) begin
			arr_r   <= 1'b0;
			rv_r    <= 1'b1;
			rresp_r <= AXI_OKAY;
			case (S_AXI_ARADDR[7:0])
				REG_CTRL:   rdata_r <= {18'h00000, ctrl_r};
				REG_STATUS: rdata_r <= status;
				default: begin
					rdata_r <= 32'h00000000;
					rresp_r <= AXI_SLVERR;
				end
			endcase
		end else if (rv_r && S_AXI_RREADY) begin
			rv_r  <= 1'b0;
			arr_r <= 1'b1;
		end
	end

	// slot engine: drive phase, then sample slot
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			busy_r   <= 1'b0;
			phase_r  <= 1'b0;
			slot_r   <= 1'b0;
			lrst_r   <= 1'b0;
			oe_r     <= 1'b0;
			crc_en_r <= 1'b0;
			nb_r     <= 4'h0;
			sh_r     <= 8'h00;
			rx_r     <= 8'h00;
			div_r    <= 2'h0;
		end else if (go) begin
			lrst_r <= wd_r[CTRL_LRST];
			if (!wd_r[CTRL_LRST]) begin
				busy_r   <= 1'b1;
				sh_r     <= wd_r[7:0];
				nb_r     <= {1'b0, wd_r[CTRL_NB_LSB +: 3]} + 4'h1;
				crc_en_r <= wd_r[CTRL_CRC_EN];
				phase_r  <= 1'b0;
				div_r    <= 2'h0;
			end
		end else begin
			lrst_r <= 1'b0;
			slot_r <= 1'b0;
			if (slot_r) begin
				rx_r <= {link.line, rx_r[7:1]};
				sh_r <= {1'b0, sh_r[7:1]};
				oe_r <= 1'b0;
				nb_r <= nb_r - 4'h1;
				if (nb_r == 4'h1) begin
					busy_r <= 1'b0;
				end
			end else if (busy_r) begin
				div_r <= div_r + 2'h1;
				if (div_r == 2'(SLOT_DIV - 1)) begin
					div_r   <= 2'h0;
					phase_r <= ~phase_r;
					if (!phase_r) begin
						oe_r <= ~sh_r[0];
					end else begin
						slot_r <= 1'b1;
					end
				end
			end
		end
	end

	// receive crc checker
	always_ff @(posedge SYS_CLK) begin
		if (RST || (go && wd_r[CTRL_CRC_CLR])) begin
			crc_r <= 8'h00;
		end else if (slot_r && crc_en_r) begin
			crc_r <= crc_step(crc_r, link.line);
		end
	end

	assign S_AXI_AWREADY = awr_r;
	assign S_AXI_WREADY  = wr_r;
	assign S_AXI_BVALID  = bv_r;
	assign S_AXI_BRESP   = bresp_r;
	assign S_AXI_ARREADY = arr_r;
	assign S_AXI_RVALID  = rv_r;
	assign S_AXI_RDATA   = rdata_r;
	assign S_AXI_RRESP   = rresp_r;
	assign link.slot     = slot_r;
	assign link.link_rst = lrst_r;
	assign link.m_oe     = oe_r;
	assign link.m_o      = 1'b0;
endmodule // thermo_master

// ===== tb/thermo_link_props.sv
// link-level checks on the shared single-line carrier
`timescale 1ns/100ps
module thermo_link_props (
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic RST,
	// link
	input wire logic slot,
	input wire logic link_rst,
	input wire logic m_o,
	input wire logic m_oe,
	input wire logic d_o,
	input wire logic d_oe,
	input wire logic line
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);

	property p_open_drain; !m_o && !d_o; endproperty
	a_open_drain: assert property (p_open_drain)
		else $error("driver data value not zero");
	property p_wired; (m_oe || d_oe) != line; endproperty
	a_wired: assert property (p_wired)
		else $error("line level disagrees with enables");
	property p_slot_space; slot |=> !slot [*7]; endproperty
	a_slot_space: assert property (p_slot_space)
		else $error("slots closer than eight cycles");
	property p_rst_pulse; link_rst |-> !slot && !m_oe ##1 !link_rst; endproperty
	a_rst_pulse: assert property (p_rst_pulse)
		else $error("link restart not a lone pulse");
	property p_release; slot |=> !m_oe; endproperty
	a_release: assert property (p_release)
		else $error("master drive held past slot");
	property p_drive_hold; $rose(m_oe) |-> (m_oe && !slot) [*4] ##1 (m_oe && slot); endproperty
	a_drive_hold: assert property (p_drive_hold)
		else $error("master drive not held four cycles before slot");
	property p_dev_answer; $rose(d_oe) |-> $past(slot, 2); endproperty
	a_dev_answer: assert property (p_dev_answer)
		else $error("sensor drive not two cycles after slot");
	property p_dev_quiet; d_oe |-> !m_oe; endproperty
	a_dev_quiet: assert property (p_dev_quiet)
		else $error("both ends pull the line");
	property p_restart_quiet; link_rst |-> ##2 !d_oe; endproperty
	a_restart_quiet: assert property (p_restart_quiet)
		else $error("sensor still pulls line after link restart");
endmodule // thermo_link_props

// ===== tb/thermometer_result_alarm_crc_tb.sv
// bench joining master and sensor ends over the shared link
`timescale 1ns/100ps
module thermometer_result_alarm_crc_tb import thermo_pkg::*;;
	localparam logic [7:0]  FAM = 8'h3c;              // arbitrary
	localparam logic [47:0] SER = 48'h0a1b_2c3d_4e5f; // arbitrary
	localparam logic [7:0]  UP  = 8'h14;
	localparam logic [7:0]  LO  = 8'hf6;
	logic        SYS_CLK, RST, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, busy, alarm, al;
	logic [31:0] awaddr, wdata, araddr, rdata, st;
	logic [1:0]  bresp, rresp, rsp;
	logic [15:0] sample, t_res, ex, prev;
	logic [15:0] sm [4];
	logic [63:0] idv;
	logic [7:0]  b, c;
	int          fail_count, comparisons, n;

	thermo_link_if lnk();
	thermo_master i_thermo_master (
		.SYS_CLK(SYS_CLK), .RST(RST),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .link(lnk)
	);
	thermo_device #(.CONV_CYCLES(64), .FAMILY(FAM), .SERIAL(SER)) i_thermo_device (
		.SYS_CLK(SYS_CLK), .RST(RST), .link(lnk), .TEMP_SAMPLE(sample),
		.TEMP_RESULT(t_res), .CONV_BUSY(busy), .ALARM(alarm)
	);
	thermo_link_props i_thermo_link_props (
		.SYS_CLK(SYS_CLK), .RST(RST), .slot(lnk.slot), .link_rst(lnk.link_rst),
		.m_o(lnk.m_o), .m_oe(lnk.m_oe), .d_o(lnk.d_o), .d_oe(lnk.d_oe), .line(lnk.line)
	);

	initial begin
		SYS_CLK = 1'b0;
		forever #2.5 SYS_CLK = ~SYS_CLK;
	end

	task automatic chk(input logic [31:0] e, input logic [31:0] s, input string nm);
		comparisons++;
		if (s !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic give_verdict;
		if (fail_count == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge SYS_CLK);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		forever begin
			@(posedge SYS_CLK);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		rsp = bresp;
		bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [31:0] a);
		@(posedge SYS_CLK);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		forever begin
			@(posedge SYS_CLK);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		st = rdata;
		rsp = rresp;
		rready <= 1'b0;
	endtask

	// one link operation, then wait until idle
	task automatic op(input logic [13:0] cw);
		axi_wr({24'h0, REG_CTRL}, {18'h0, cw});
		n = 0;
		do begin
			axi_rd({24'h0, REG_STATUS});
			n++;
		end while (st[16] && n < 200);
		chk(0, st[16], "link idle after operation");
	endtask

	task automatic tx(input logic [7:0] d);
		op({6'h07, d});
	endtask

	task automatic rx(input logic clr);
		op({1'b0, clr, 1'b1, 3'b111, 8'hff});
		b = st[7:0];
	endtask

	task automatic start(input logic [7:0] cmd);
		op(14'h2000);
		tx(CMD_SKIP_ID);
		tx(cmd);
	endtask

	function automatic logic [7:0] crc8(input logic [7:0] cc, input logic [7:0] d);
		for (int i = 0; i < 8; i++) begin
			cc = (cc >> 1) ^ ((cc[0] ^ d[i]) ? 8'h8c : 8'h00);
		end
		return cc;
	endfunction

	task automatic sp_chk(input logic [7:0] u, input logic [7:0] l, input logic [1:0] r,
		input logic [15:0] t);
		logic [7:0] e [9];
		e = '{t[7:0], t[15:8], u, l, {1'b0, r, CFG_ONES}, SP_RSV5, SP_RSV6, SP_RSV7, 8'h00};
		for (int i = 0; i < 8; i++) begin
			e[8] = crc8(e[8], e[i]);
		end
		start(CMD_READ_SP);
		for (int i = 0; i < 9; i++) begin
			rx(i == 0);
			chk(e[i], b, "scratchpad byte");
		end
		chk(1, st[17], "scratchpad crc residue");
	endtask

	initial begin
		repeat (60000) @(posedge SYS_CLK);
		fail_count++;
		give_verdict();
	end

	initial begin
		RST = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, wdata, araddr} = '0;
		sample = 16'h0000;
		fail_count = 0;
		comparisons = 0;
		sm = '{16'hff5e, 16'h00a2, 16'h0191, 16'h0008};
		repeat (16) @(posedge SYS_CLK);
		RST <= 1'b0;
		@(posedge SYS_CLK);
		chk(TEMP_RST, t_res, "result after reset");
		axi_rd(32'h0000_0008);
		chk(AXI_SLVERR, rsp, "unmapped read response");
		chk(0, st, "unmapped read data");
		axi_wr(32'h0000_000c, 32'h0);
		chk(AXI_SLVERR, rsp, "unmapped write response");
		// function command with no id command first
		op(14'h2000);
		tx(CMD_READ_SP);
		rx(1'b0);
		chk(8'hff, b, "reply without id command");
		sp_chk(UPPER_RST, LOWER_RST, RES_RST, TEMP_RST);
		idv = {8'h00, SER, FAM};
		c = 8'h00;
		for (int i = 0; i < 7; i++) c = crc8(c, idv[8*i+:8]);
		idv[63:56] = c;
		op(14'h2000);
		tx(CMD_READ_ID);
		for (int i = 0; i < 8; i++) begin
			rx(i == 0);
			chk(idv[8*i+:8], b, "id byte");
		end
		chk(1, st[17], "id crc residue");
		// addressed access by full id code
		op(14'h2000);
		tx(CMD_MATCH_ID);
		for (int i = 0; i < 8; i++) begin
			tx(idv[8*i+:8]);
		end
		tx(CMD_READ_SP);
		rx(1'b1);
		chk(TEMP_RST[7:0], b, "result byte after id match");
		// wrong id code leaves the sensor silent
		op(14'h2000);
		tx(CMD_MATCH_ID);
		tx(~FAM);
		tx(CMD_READ_SP);
		rx(1'b1);
		chk(8'hff, b, "reply after failed id match");
		prev = TEMP_RST;
		for (int r = 0; r < 4; r++) begin
			ex = sm[r] & (16'hffff << (3 - r));
			al = ($signed(ex[11:4]) > $signed(UP)) || ($signed(ex[11:4]) < $signed(LO));
			start(CMD_WRITE_SP);
			tx(UP);
			tx(LO);
			tx({1'b0, r[1:0], 5'h1f});
			sample <= sm[r];
			start(CMD_CONVERT);
			if (r > 1) begin
				chk(1, busy, "busy during conversion");
				chk(prev, t_res, "result during conversion");
			end
			n = 0;
			while (busy !== 1'b0 && n < 300) begin
				@(posedge SYS_CLK);
				n++;
			end
			chk(0, busy, "busy after conversion");
			chk(ex, t_res, "converted result");
			chk(al, alarm, "alarm flag");
			op(14'h2000);
			tx(CMD_ALARM_SRC);
			op(14'h0103);
			chk(al ? {~FAM[0], FAM[0]} : 2'b11, st[7:6], "alarm search reply");
			sp_chk(UP, LO, r[1:0], ex);
			prev = ex;
		end
		give_verdict();
	end
endmodule // thermometer_result_alarm_crc_tb
